// File: core/msm_pkg.sv
// shared constants for the mitigation status, injection and monitor block
package msm_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_INJ_LO  = 8'h08;
  localparam logic [7:0] REG_INJ_HI  = 8'h0C;
  localparam logic [7:0] REG_OUTCOME = 8'h10;

  // control register fields
  localparam int CTRL_CORR_EN  = 0;
  localparam int CTRL_CLASS_EN = 1;

  // outcome register fields
  localparam int OUT_UNCORR = 0;
  localparam int OUT_ESSENT = 1;
  localparam int OUT_FATAL  = 2;

  // status register fields
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_UNCORR    = 5;
  localparam int STAT_ESSENT    = 6;

  // reset values
  localparam logic [1:0] CTRL_RST    = 2'h3;
  localparam logic [2:0] OUTCOME_RST = 3'h0;

  // injection address widths
  localparam int INJ_W_WIDE   = 40;
  localparam int INJ_W_NARROW = 36;

  // heartbeat intervals in cycles
  localparam logic [9:0] HB_WIDE   = 10'h080;
  localparam logic [9:0] HB_NARROW = 10'h200;

  // phase counter reload values; a phase lasts one cycle more than its value
  localparam logic [7:0] INIT_CYC      = 8'h20;
  localparam logic [7:0] QUERY_CYC     = 8'h08;
  localparam logic [7:0] CORR_CYC      = 8'h10;
  localparam logic [7:0] CORR_PASS_CYC = 8'h02;
  localparam logic [7:0] CLASS_CYC     = 8'h10;
  localparam logic [7:0] CLASS_PASS_CYC = 8'h02;
  localparam logic [7:0] INJ_CYC       = 8'h0C;

  // monitor ascii characters and last report byte index
  localparam logic [7:0] CH_IDLE   = 8'h49;
  localparam logic [7:0] CH_OBS    = 8'h4F;
  localparam logic [7:0] CH_STAT   = 8'h53;
  localparam logic [7:0] CH_CORR   = 8'h43;
  localparam logic [7:0] CH_CLASS  = 8'h4C;
  localparam logic [7:0] CH_INJ    = 8'h4A;
  localparam logic [7:0] CH_IDLEST = 8'h44;
  localparam logic [7:0] CH_HALT   = 8'h48;
  localparam logic [7:0] CH_INIT   = 8'h4E;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [1:0] REPORT_LAST = 2'h2;

  // controller phases
  typedef enum logic [2:0] {
    ST_INIT, ST_OBS, ST_QUERY, ST_CORR, ST_CLASS, ST_INJ, ST_IDLE, ST_HALT
  } msm_state_t;

endpackage

// File: core/msm_core.sv
// mitigation controller status outputs, injection port and ascii monitor channel
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps

module msm_core #(
  parameter bit WIDE_FRAME  = 1'b1,
  parameter bit NARROW_PORT = 1'b0,
  parameter int INJ_W       = WIDE_FRAME ? msm_pkg::INJ_W_WIDE : msm_pkg::INJ_W_NARROW
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  // register port
  input  wire logic [msm_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [msm_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [msm_pkg::DATA_W-1:0] reg_rdata,
  // detection hardware
  input  wire logic                       detect_error,
  // status outputs
  output logic                            status_heartbeat,
  output logic                            status_initialization,
  output logic                            status_observation,
  output logic                            status_correction,
  output logic                            status_classification,
  output logic                            status_injection,
  output logic                            status_essential,
  output logic                            status_uncorrectable,
  // injection request
  input  wire logic                       inject_strobe,
  input  wire logic [INJ_W-1:0]           inject_address,
  // monitor channel
  output logic      [7:0]                 monitor_txdata,
  output logic                            monitor_txwrite,
  input  wire logic                       monitor_txfull,
  input  wire logic [7:0]                 monitor_rxdata,
  output logic                            monitor_rxread,
  input  wire logic                       monitor_rxempty
);

  // state and registers
  msm_pkg::msm_state_t state_r, state_nxt;
  logic [7:0]       cnt_r, cnt_nxt;
  logic [9:0]       hb_cnt_r;
  logic [1:0]       ctrl_r;
  logic [2:0]       outcome_r;
  logic [INJ_W-1:0] inj_addr_r;
  logic             unc_r, ess_r;
  logic             fatal_r;
  logic             tx_busy_r;
  logic [1:0]       tx_idx_r;

  // register decode
  wire        hit_ctrl    = reg_addr == msm_pkg::REG_CTRL;
  wire        hit_status  = reg_addr == msm_pkg::REG_STATUS;
  wire        hit_inj_lo  = reg_addr == msm_pkg::REG_INJ_LO;
  wire        hit_inj_hi  = reg_addr == msm_pkg::REG_INJ_HI;
  wire        hit_outcome = reg_addr == msm_pkg::REG_OUTCOME;
  wire        corr_en     = ctrl_r[msm_pkg::CTRL_CORR_EN];
  wire        class_en    = ctrl_r[msm_pkg::CTRL_CLASS_EN];
  wire [9:0]  hb_limit    = NARROW_PORT ? msm_pkg::HB_NARROW : msm_pkg::HB_WIDE;
  wire        cnt_done    = cnt_r == 8'h00;
  wire        cnt_last    = cnt_r == 8'h01;

  // monitor receive decode; rxread already high means the empty flag may lag
  wire        rx_take     = !monitor_rxempty && !monitor_rxread && !tx_busy_r;
  wire        cmd_idle    = rx_take && monitor_rxdata == msm_pkg::CH_IDLE;
  wire        cmd_obs     = rx_take && monitor_rxdata == msm_pkg::CH_OBS;
  wire        cmd_stat    = rx_take && monitor_rxdata == msm_pkg::CH_STAT;
  wire        inj_take    = inject_strobe && state_r == msm_pkg::ST_IDLE;

  // phase sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_done ? 8'h00 : cnt_r - 8'h01;
    unique case (state_r)
      msm_pkg::ST_INIT: begin
        if (cnt_done) begin
          state_nxt = msm_pkg::ST_OBS;
        end
      end
      msm_pkg::ST_OBS: begin
        if (detect_error) begin
          state_nxt = msm_pkg::ST_QUERY;
          cnt_nxt   = msm_pkg::QUERY_CYC;
        end else if (cmd_idle) begin
          state_nxt = msm_pkg::ST_IDLE;
        end
      end
      msm_pkg::ST_QUERY: begin
        if (cnt_done) begin
          state_nxt = msm_pkg::ST_CORR;
          cnt_nxt   = corr_en ? msm_pkg::CORR_CYC : msm_pkg::CORR_PASS_CYC;
        end
      end
      msm_pkg::ST_CORR: begin
        if (cnt_done) begin
          state_nxt = msm_pkg::ST_CLASS;
          cnt_nxt   = class_en ? msm_pkg::CLASS_CYC : msm_pkg::CLASS_PASS_CYC;
        end
      end
      msm_pkg::ST_CLASS: begin
        if (cnt_done) begin
          state_nxt = fatal_r ? msm_pkg::ST_HALT : msm_pkg::ST_OBS;
        end
      end
      msm_pkg::ST_INJ: begin
        if (cnt_done) begin
          state_nxt = msm_pkg::ST_IDLE;
        end
      end
      msm_pkg::ST_IDLE: begin
        if (inj_take) begin
          state_nxt = msm_pkg::ST_INJ;
          cnt_nxt   = msm_pkg::INJ_CYC;
        end else if (cmd_obs) begin
          state_nxt = msm_pkg::ST_OBS;
        end
      end
      msm_pkg::ST_HALT: begin
        state_nxt = msm_pkg::ST_HALT;
      end
    endcase
  end

  // state outputs decoded from the next phase so they change with the phase itself
  wire nx_init  = state_nxt == msm_pkg::ST_INIT;
  wire nx_obs   = state_nxt == msm_pkg::ST_OBS || state_nxt == msm_pkg::ST_QUERY;
  wire nx_corr  = state_nxt == msm_pkg::ST_CORR;
  wire nx_class = state_nxt == msm_pkg::ST_CLASS;
  wire nx_inj   = state_nxt == msm_pkg::ST_INJ;
  wire nx_halt  = state_nxt == msm_pkg::ST_HALT;

  // flag updates one cycle before the phase is left
  wire unc_upd = state_r == msm_pkg::ST_CORR && cnt_last;
  wire ess_upd = state_r == msm_pkg::ST_CLASS && cnt_last;
  wire unc_val = corr_en ? outcome_r[msm_pkg::OUT_UNCORR] : 1'b1;
  wire ess_val = class_en ? outcome_r[msm_pkg::OUT_ESSENT] : 1'b1;

  // heartbeat counter runs only while observing
  wire hb_fire = nx_obs && hb_cnt_r == hb_limit - 10'h001;

  // phase, counter and outputs; async reset takes constants, init phase is the sync start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= msm_pkg::ST_INIT;
      cnt_r   <= msm_pkg::INIT_CYC;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_initialization <= 1'b1;
      status_observation    <= 1'b0;
      status_correction     <= 1'b0;
      status_classification <= 1'b0;
      status_injection      <= 1'b0;
    end else begin
      status_initialization <= nx_init || nx_halt;
      status_observation    <= nx_obs || nx_halt;
      status_correction     <= nx_corr || nx_halt;
      status_classification <= nx_class || nx_halt;
      status_injection      <= nx_inj || nx_halt;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_cnt_r         <= 10'h000;
      status_heartbeat <= 1'b0;
    end else begin
      hb_cnt_r         <= (!nx_obs || hb_fire) ? 10'h000 : hb_cnt_r + 10'h001;
      status_heartbeat <= hb_fire;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unc_r                <= 1'b0;
      ess_r                <= 1'b0;
      fatal_r              <= 1'b0;
      status_uncorrectable <= 1'b0;
      status_essential     <= 1'b0;
    end else begin
      if (unc_upd) begin
        unc_r                <= unc_val;
        status_uncorrectable <= unc_val;
        fatal_r              <= unc_val && outcome_r[msm_pkg::OUT_FATAL];
      end
      if (ess_upd) begin
        ess_r            <= ess_val;
        status_essential <= ess_val;
      end
    end
  end

  // injection address capture, same cycle as the accepted strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inj_addr_r <= '0;
    end else if (inj_take) begin
      inj_addr_r <= inject_address;
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r    <= msm_pkg::CTRL_RST;
      outcome_r <= msm_pkg::OUTCOME_RST;
    end else if (reg_wr) begin
      if (hit_ctrl) begin
        ctrl_r <= reg_wdata[1:0];
      end
      if (hit_outcome) begin
        outcome_r <= reg_wdata[2:0];
      end
    end
  end

  // register read mux; unmapped offsets read zero
  wire [4:0]               state_bits = {status_injection, status_classification,
                                         status_correction, status_observation,
                                         status_initialization};
  wire [63:0]              inj_wide   = 64'(inj_addr_r);
  wire [msm_pkg::DATA_W-1:0] rd_ctrl  = {30'h0, ctrl_r};
  wire [msm_pkg::DATA_W-1:0] rd_stat  = {25'h0, ess_r, unc_r, state_bits};
  wire [msm_pkg::DATA_W-1:0] rd_out   = {29'h0, outcome_r};
  wire [msm_pkg::DATA_W-1:0] rd_mux   = hit_ctrl    ? rd_ctrl :
                                        hit_status  ? rd_stat :
                                        hit_inj_lo  ? inj_wide[31:0] :
                                        hit_inj_hi  ? inj_wide[63:32] :
                                        hit_outcome ? rd_out : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // status report: state letter, flag digit, carriage return
  logic [7:0] state_ch;
  always_comb begin
    state_ch = msm_pkg::CH_INIT;
    unique case (state_r)
      msm_pkg::ST_INIT:  state_ch = msm_pkg::CH_INIT;
      msm_pkg::ST_OBS:   state_ch = msm_pkg::CH_OBS;
      msm_pkg::ST_QUERY: state_ch = msm_pkg::CH_OBS;
      msm_pkg::ST_CORR:  state_ch = msm_pkg::CH_CORR;
      msm_pkg::ST_CLASS: state_ch = msm_pkg::CH_CLASS;
      msm_pkg::ST_INJ:   state_ch = msm_pkg::CH_INJ;
      msm_pkg::ST_IDLE:  state_ch = msm_pkg::CH_IDLEST;
      msm_pkg::ST_HALT:  state_ch = msm_pkg::CH_HALT;
    endcase
  end

  wire [7:0] flag_ch  = msm_pkg::CH_ZERO + {6'h00, ess_r, unc_r};
  wire [7:0] tx_byte  = tx_idx_r == 2'h0 ? state_ch :
                        tx_idx_r == 2'h1 ? flag_ch : msm_pkg::CH_CR;
  // full is sampled one cycle ahead of the strobe; the peripheral needs one slot of slack
  wire       tx_go    = tx_busy_r && !monitor_txfull;
  wire       tx_end   = tx_go && tx_idx_r == msm_pkg::REPORT_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy_r       <= 1'b0;
      tx_idx_r        <= 2'h0;
      monitor_txwrite <= 1'b0;
      monitor_txdata  <= 8'h00;
    end else begin
      tx_busy_r       <= cmd_stat || (tx_busy_r && !tx_end);
      tx_idx_r        <= cmd_stat ? 2'h0 : (tx_go ? tx_idx_r + 2'h1 : tx_idx_r);
      monitor_txwrite <= tx_go;
      monitor_txdata  <= tx_go ? tx_byte : monitor_txdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_rxread <= 1'b0;
    end else begin
      monitor_rxread <= rx_take;
    end
  end

endmodule // msm_core

// File: tb/msm_core_properties.sv
// concurrent checks on the status, injection and monitor ports
`timescale 1ns/100ps
module msm_core_properties #(
  parameter bit NARROW_PORT = 1'h0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // status and injection
  input wire logic detect_error,
  input wire logic status_heartbeat,
  input wire logic status_initialization,
  input wire logic status_observation,
  input wire logic status_correction,
  input wire logic status_classification,
  input wire logic status_injection,
  input wire logic status_essential,
  input wire logic status_uncorrectable,
  input wire logic inject_strobe,
  // monitor handshake
  input wire logic monitor_txwrite,
  input wire logic monitor_txfull,
  input wire logic monitor_rxread,
  input wire logic monitor_rxempty
);
  localparam int HB_LIM = NARROW_PORT ? 512 : 128;
  logic [9:0] hb_gap_r;
  logic       left_init_r;
  wire  [4:0] st_w   = {status_injection, status_classification, status_correction,
                        status_observation, status_initialization};
  wire        idle_w = (st_w == 5'h00);
  wire        halt_w = (st_w == 5'h1F);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // gap cleared outside observation, where pulse timing means nothing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hb_gap_r    <= 10'h000;
      left_init_r <= 1'h0;
    end else begin
      hb_gap_r    <= (status_heartbeat || !status_observation || halt_w) ? 10'h000
                     : hb_gap_r + 10'h001;
      left_init_r <= left_init_r || !status_initialization;
    end
  end
  sequence s_inj_req;
    inject_strobe && idle_w;
  endsequence
  sequence s_inj_run;
    (status_injection throughout (##12 1'h1)) ##1 idle_w;
  endsequence
  AST_HB_GAP: assert property (hb_gap_r < HB_LIM)
    else $error("heartbeat gap too long");
  AST_HB_PULSE: assert property (status_heartbeat |=> !status_heartbeat)
    else $error("heartbeat wider than one cycle");
  AST_STATE_CODE: assert property ($onehot(st_w) || idle_w || halt_w)
    else $error("illegal state output combination");
  AST_INIT_ONCE: assert property (left_init_r |-> !status_initialization || halt_w)
    else $error("initialization seen twice");
  AST_QUERY_OBS: assert property (status_observation && detect_error |=>
    status_observation[*8])
    else $error("observation dropped during query");
  AST_CORR_RUN: assert property ($rose(status_correction) && !status_initialization |->
    status_correction[*3] ##[1:15] (status_classification && !status_correction))
    else $error("correction phase malformed");
  AST_UNC_FLAG: assert property ($changed(status_uncorrectable) |->
    status_correction ##1 status_classification)
    else $error("uncorrectable flag moved at wrong time");
  AST_ESS_FLAG: assert property ($changed(status_essential) |->
    status_classification ##1 status_observation)
    else $error("essential flag moved at wrong time");
  AST_INJ_RUN: assert property (s_inj_req |=> s_inj_run)
    else $error("injection phase malformed");
  AST_TX_FULL: assert property (monitor_txwrite |-> !$past(monitor_txfull))
    else $error("byte written while full");
  AST_RX_EMPTY: assert property (monitor_rxread |->
    !$past(monitor_rxempty) ##1 !monitor_rxread)
    else $error("read strobe while empty");
endmodule // msm_core_properties

// File: tb/msm_shim_model.sv
// monitor peripheral model: receive queue and throttled transmit queue
`timescale 1ns/100ps
module msm_shim_model (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // receive side
  output logic     [7:0] monitor_rxdata,
  output logic           monitor_rxempty,
  input wire logic       monitor_rxread,
  // transmit side
  input wire logic [7:0] monitor_txdata,
  input wire logic       monitor_txwrite,
  output logic           monitor_txfull,
  // bench control
  input wire logic       stall
);
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  int         pend;
  int         overflow;
  task send_byte(input logic [7:0] b);
    rx_q.push_back(b);
  endtask
  // full one slot early, the device looks a cycle ahead
  assign monitor_txfull = stall || (pend >= 3);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      monitor_rxempty <= 1'h1;
      monitor_rxdata  <= 8'h00;
      pend            <= 0;
      overflow        <= 0;
    end else begin
      if (monitor_rxread && rx_q.size() > 0) void'(rx_q.pop_front());
      monitor_rxempty <= (rx_q.size() == 0);
      monitor_rxdata  <= (rx_q.size() > 0) ? rx_q[0] : ~monitor_rxdata;
      if (monitor_txwrite) tx_q.push_back(monitor_txdata);
      if (monitor_txwrite && pend >= 4) overflow <= overflow + 1;
      pend <= pend + (monitor_txwrite ? 1 : 0) - ((!stall && pend > 0) ? 1 : 0);
    end
  end
endmodule // msm_shim_model

// File: tb/tb_msm_core.sv
// testbench for the mitigation status, injection and monitor block
`timescale 1ns/100ps
module tb_msm_core;
  logic        clk, rst_n, reg_wr, reg_rd, detect_error, inject_strobe, stall;
  logic [7:0]  reg_addr, monitor_txdata, monitor_rxdata;
  logic [31:0] reg_wdata, reg_rdata;
  logic [39:0] inject_address;
  logic        status_heartbeat, status_initialization, status_observation;
  logic        status_correction, status_classification, status_injection;
  logic        status_essential, status_uncorrectable;
  logic        monitor_txwrite, monitor_txfull, monitor_rxread, monitor_rxempty;
  int          errors = 0, check_count = 0, cyc = 0, hb_cnt = 0;
  wire  [4:0]  st = {status_injection, status_classification, status_correction,
                     status_observation, status_initialization};
  msm_core #(.WIDE_FRAME(1'h1), .NARROW_PORT(1'h0)) dut (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .detect_error,
    .status_heartbeat, .status_initialization, .status_observation, .status_correction,
    .status_classification, .status_injection, .status_essential, .status_uncorrectable,
    .inject_strobe, .inject_address, .monitor_txdata, .monitor_txwrite, .monitor_txfull,
    .monitor_rxdata, .monitor_rxread, .monitor_rxempty);
  msm_shim_model shim (.clk, .rst_n, .monitor_rxdata, .monitor_rxempty, .monitor_rxread,
    .monitor_txdata, .monitor_txwrite, .monitor_txfull, .stall);
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (status_heartbeat) hb_cnt <= hb_cnt + 1;
    if (cyc == 6000) begin
      errors = errors + 1;
      give_verdict();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task give_verdict();
    $display("checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 check(reg_rdata, exp);
  endtask
  task wait_st(input logic [4:0] exp);
    int n;
    for (n = 0; n < 60 && st !== exp; n++) begin
      @(posedge clk);
      #1;
    end
    check(32'(st), 32'(exp));
  endtask
  task cmd(input logic [7:0] b);
    @(posedge clk);
    #1 shim.send_byte(b);
  endtask
  task expect_report(input logic [7:0] b0, input logic [7:0] b1);
    int n;
    for (n = 0; n < 200 && shim.tx_q.size() < 3; n++) @(posedge clk);
    check(32'(shim.tx_q.size()), 32'h3);
    check(32'(shim.tx_q[0]), 32'(b0));
    check(32'(shim.tx_q[1]), 32'(b1));
    check(32'(shim.tx_q[2]), 32'(msm_pkg::CH_CR));
    shim.tx_q.delete();
  endtask
  task run_detect(input int cl, input int kl, input logic u, input logic e, input logic [4:0] f);
    int i;
    @(posedge clk);
    detect_error <= 1'h1;
    @(posedge clk);
    detect_error <= 1'h0;
    // query is entered at the edge that takes the detection; first look is one edge later
    for (i = 1; i <= 9 + cl + kl; i++) begin
      @(posedge clk);
      #1;
      check(32'(st), (i < 9) ? 32'h2 : (i < 9 + cl) ? 32'h4 : (i < 9 + cl + kl) ? 32'h8
        : 32'(f));
      if (i == 8 + cl) check(32'(status_uncorrectable), 32'(u));
      if (i == 8 + cl + kl) check(32'(status_essential), 32'(e));
    end
  endtask
  task inject(input logic [39:0] a);
    int i;
    @(posedge clk);
    inject_strobe  <= 1'h1;
    inject_address <= a;
    @(posedge clk);
    inject_strobe  <= 1'h0;
    inject_address <= ~a;
    for (i = 1; i <= 13; i++) begin
      @(posedge clk);
      #1 check(32'(st), (i < 13) ? 32'h10 : 32'h0);
    end
    reg_check(msm_pkg::REG_INJ_LO, a[31:0]);
    reg_check(msm_pkg::REG_INJ_HI, 32'(a[39:32]));
  endtask
  initial begin
    int hb_base;
    {rst_n, reg_wr, reg_rd, detect_error, inject_strobe, stall} = 6'h00;
    {reg_addr, reg_wdata, inject_address} = 80'h0;
    repeat (8) @(posedge clk);
    #1 check(32'(st), 32'h1);
    @(posedge clk);
    rst_n <= 1'h1;
    wait_st(5'h02);
    // counter has one driver; the window is measured from a snapshot
    hb_base = hb_cnt;
    repeat (300) @(posedge clk);
    check(32'(hb_cnt - hb_base >= 2), 32'h1);
    reg_check(msm_pkg::REG_CTRL, 32'h3);
    reg_check(8'h14, 32'h0);
    reg_write(msm_pkg::REG_OUTCOME, 32'h1);
    run_detect(17, 17, 1'h1, 1'h0, 5'h02);
    cmd(msm_pkg::CH_STAT);
    expect_report(msm_pkg::CH_OBS, 8'h31);
    $display("test detection with full phases done");
    reg_write(msm_pkg::REG_CTRL, 32'h0);
    reg_write(msm_pkg::REG_OUTCOME, 32'h0);
    run_detect(3, 3, 1'h1, 1'h1, 5'h02);
    @(posedge clk);
    stall <= 1'h1;
    cmd(msm_pkg::CH_STAT);
    repeat (20) @(posedge clk);
    check(32'(shim.tx_q.size()), 32'h0);
    stall <= 1'h0;
    expect_report(msm_pkg::CH_OBS, 8'h33);
    $display("test disabled phases and throttle done");
    cmd(msm_pkg::CH_IDLE);
    wait_st(5'h00);
    // unknown command byte is taken and dropped without effect
    cmd(8'h5A);
    repeat (6) @(posedge clk);
    check(32'(st), 32'h0);
    check(32'(shim.tx_q.size()), 32'h0);
    check(32'(shim.rx_q.size()), 32'h0);
    inject(40'hA5_1234_5678);
    inject(40'h3C_8765_4321);
    cmd(msm_pkg::CH_STAT);
    expect_report(msm_pkg::CH_IDLEST, 8'h33);
    cmd(msm_pkg::CH_OBS);
    wait_st(5'h02);
    $display("test injection done");
    reg_write(msm_pkg::REG_OUTCOME, 32'h5);
    run_detect(3, 3, 1'h1, 1'h1, 5'h1F);
    check(32'(shim.overflow), 32'h0);
    @(posedge clk);
    rst_n <= 1'h0;
    repeat (8) @(posedge clk);
    #1 check(32'(st), 32'h1);
    rst_n <= 1'h1;
    wait_st(5'h02);
    reg_check(msm_pkg::REG_CTRL, 32'h3);
    $display("test halt and second reset done");
    give_verdict();
  end
endmodule // tb_msm_core
bind msm_core msm_core_properties #(.NARROW_PORT(NARROW_PORT)) u_props (
  .clk, .rst_n, .detect_error, .status_heartbeat, .status_initialization,
  .status_observation, .status_correction, .status_classification, .status_injection,
  .status_essential, .status_uncorrectable, .inject_strobe, .monitor_txwrite,
  .monitor_txfull, .monitor_rxread, .monitor_rxempty);
